// ### logic/nr_mtx_pkg.sv
// Purpose: Shared constants and types of the noise reducer and colour matrices.
// Assumes: One 8-bit sample per component per pixel.
// Notes: Register word offsets are byte addresses on the plain register port.
package nr_mtx_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int PIX_W = 8;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int NUM_COMP = 3;
	localparam int NUM_MTX = 3;
	localparam int NUM_OFFS = 3;
	localparam int NUM_GAIN = 9;
	localparam int HIST_DEPTH = 4;
	localparam int TH_W = 7;
	localparam int TAP_W = 2;
	localparam int NRG_W = 2;
	localparam int GAIN_W = 11;
	localparam int OFFS_W = 8;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADDR_NR_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_NR_PARAM = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_MTX_BASE = 8'h40;
	localparam logic [ADDR_W-1:0] MTX_STRIDE = 8'h40;
	localparam logic [ADDR_W-1:0] MTX_MODE_OFS = 8'h00;
	localparam logic [ADDR_W-1:0] MTX_OFFS_OFS = 8'h04;
	localparam logic [ADDR_W-1:0] MTX_GAIN_OFS = 8'h10;
	localparam logic [ADDR_W-1:0] WORD_STEP = 8'h04;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int NR_EN_BIT = 0;
	localparam int TH_LSB = 0;
	localparam int TAP_LSB = 8;
	localparam int NRG_LSB = 12;
	localparam int STAT_REFUSED_BIT = 0;
	localparam int STAT_NR_ON_BIT = 1;

	// ----------------------------------------------------------------
	// Reset values and arithmetic constants
	// ----------------------------------------------------------------
	localparam logic [TH_W-1:0] TH_RST = 7'h08;
	localparam logic [TAP_W-1:0] TAP_RST = 2'h0;
	localparam logic [NRG_W-1:0] NRG_RST = 2'h3;
	localparam logic [OFFS_W-1:0] OFFS_RST = 8'h80;
	localparam logic [GAIN_W-1:0] GAIN_UNITY = 11'h100;
	localparam logic [GAIN_W-1:0] GAIN_ZERO = 11'h000;
	localparam int OFFS_ZERO = 128;
	localparam int CHROMA_MID = 128;
	localparam int UNITY_SHIFT = 8;
	localparam int PIX_MAX = 255;
	localparam int RECIP_SHIFT = 8;
	localparam int RECIP_1 = 256;
	localparam int RECIP_2 = 128;
	localparam int RECIP_3 = 85;
	localparam int RECIP_4 = 64;
	localparam int MOD_INPUT_CTRL = 0;

	typedef enum logic [1:0] {
		MODE_GBR_GBR,
		MODE_GBR_YCC,
		MODE_YCC_GBR,
		MODE_YCC_YCC
	} mtx_mode_t;

endpackage

// ### logic/video_nr_color_matrix.sv
// Purpose: Horizontal noise reducer followed by three 3x3 colour matrices.
// Assumes: Pixel inputs synchronous to CORE_CLK_I; one pixel per valid.
// Notes: Latency is four clocks from an input pixel to its output.
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module video_nr_color_matrix
	import nr_mtx_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [DATA_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [DATA_W-1:0] REG_RDATA_O,
	input wire logic PIX_VALID_I,
	input wire logic LINE_START_I,
	input wire logic [PIX_W-1:0] PIX_YG_I,
	input wire logic [PIX_W-1:0] PIX_CBB_I,
	input wire logic [PIX_W-1:0] PIX_CRR_I,
	output logic PIX_VALID_O,
	output logic [PIX_W-1:0] PIX_YG_O,
	output logic [PIX_W-1:0] PIX_CBB_O,
	output logic [PIX_W-1:0] PIX_CRR_O
);

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic nr_enable_reg, nr_enable_next;
	logic [TH_W-1:0] th_reg [NUM_COMP];
	logic [TH_W-1:0] th_next [NUM_COMP];
	logic [TAP_W-1:0] tap_reg [NUM_COMP];
	logic [TAP_W-1:0] tap_next [NUM_COMP];
	logic [NRG_W-1:0] nrg_reg [NUM_COMP];
	logic [NRG_W-1:0] nrg_next [NUM_COMP];
	mtx_mode_t mode_reg [NUM_MTX];
	mtx_mode_t mode_next [NUM_MTX];
	logic [OFFS_W-1:0] offs_reg [NUM_MTX][NUM_OFFS];
	logic [OFFS_W-1:0] offs_next [NUM_MTX][NUM_OFFS];
	logic [GAIN_W-1:0] gain_reg [NUM_MTX][NUM_GAIN];
	logic [GAIN_W-1:0] gain_next [NUM_MTX][NUM_GAIN];
	logic refused_reg, refused_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;

	always_comb begin
		logic [ADDR_W-1:0] base;
		logic refuse_set;
		base = '0;
		refuse_set = 1'b0;
		nr_enable_next = nr_enable_reg;
		th_next = th_reg;
		tap_next = tap_reg;
		nrg_next = nrg_reg;
		mode_next = mode_reg;
		offs_next = offs_reg;
		gain_next = gain_reg;
		rdata_next = '0;
		if (REG_WR_I && REG_ADDR_I == ADDR_NR_CTRL) begin
			// Only the enable moves; the parameter sets stay put.
			nr_enable_next = REG_WDATA_I[NR_EN_BIT];
		end
		if (REG_RD_I && REG_ADDR_I == ADDR_NR_CTRL) begin
			rdata_next[NR_EN_BIT] = nr_enable_reg;
		end
		if (REG_RD_I && REG_ADDR_I == ADDR_STATUS) begin
			rdata_next[STAT_REFUSED_BIT] = refused_reg;
			rdata_next[STAT_NR_ON_BIT] = nr_enable_reg;
		end
		for (int c = 0; c < NUM_COMP; c++) begin
			base = ADDR_W'(ADDR_NR_PARAM + c * WORD_STEP);
			if (REG_ADDR_I == base) begin
				if (REG_WR_I) begin
					// Each component owns its own word.
					th_next[c] = REG_WDATA_I[TH_LSB +: TH_W];
					tap_next[c] = REG_WDATA_I[TAP_LSB +: TAP_W];
					nrg_next[c] = REG_WDATA_I[NRG_LSB +: NRG_W];
				end
				if (REG_RD_I) begin
					rdata_next[TH_LSB +: TH_W] = th_reg[c];
					rdata_next[TAP_LSB +: TAP_W] = tap_reg[c];
					rdata_next[NRG_LSB +: NRG_W] = nrg_reg[c];
				end
			end
		end
		for (int m = 0; m < NUM_MTX; m++) begin
			base = ADDR_W'(ADDR_MTX_BASE + m * MTX_STRIDE);
			if (REG_ADDR_I == ADDR_W'(base + MTX_MODE_OFS)) begin
				if (REG_WR_I) begin
					// An improver cannot produce YCbCr, so such a write is
					// dropped and flagged rather than half applied.
					if (m != MOD_INPUT_CTRL &&
						(mtx_mode_t'(REG_WDATA_I[1:0]) == MODE_GBR_YCC ||
						mtx_mode_t'(REG_WDATA_I[1:0]) == MODE_YCC_YCC)) begin
						refuse_set = 1'b1;
					end else begin
						mode_next[m] = mtx_mode_t'(REG_WDATA_I[1:0]);
					end
				end
				if (REG_RD_I) begin
					rdata_next[1:0] = mode_reg[m];
				end
			end
			for (int i = 0; i < NUM_OFFS; i++) begin
				if (REG_ADDR_I ==
					ADDR_W'(base + MTX_OFFS_OFS + i * WORD_STEP)) begin
					if (REG_WR_I) begin
						offs_next[m][i] = REG_WDATA_I[OFFS_W-1:0];
					end
					if (REG_RD_I) begin
						rdata_next[OFFS_W-1:0] = offs_reg[m][i];
					end
				end
			end
			for (int g = 0; g < NUM_GAIN; g++) begin
				if (REG_ADDR_I ==
					ADDR_W'(base + MTX_GAIN_OFS + g * WORD_STEP)) begin
					if (REG_WR_I) begin
						gain_next[m][g] = REG_WDATA_I[GAIN_W-1:0];
					end
					if (REG_RD_I) begin
						rdata_next[GAIN_W-1:0] = gain_reg[m][g];
					end
				end
			end
		end
		refused_next = refused_reg;
		if (REG_WR_I && REG_ADDR_I == ADDR_STATUS &&
			REG_WDATA_I[STAT_REFUSED_BIT]) begin
			refused_next = 1'b0;
		end
		// A refusal in the clearing cycle is kept.
		if (refuse_set) begin
			refused_next = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			nr_enable_reg <= 1'b0;
			refused_reg <= 1'b0;
			rdata_reg <= '0;
			for (int c = 0; c < NUM_COMP; c++) begin
				th_reg[c] <= TH_RST;
				tap_reg[c] <= TAP_RST;
				nrg_reg[c] <= NRG_RST;
			end
			for (int m = 0; m < NUM_MTX; m++) begin
				mode_reg[m] <= MODE_GBR_GBR;
				for (int i = 0; i < NUM_OFFS; i++) begin
					offs_reg[m][i] <= OFFS_RST;
				end
				for (int g = 0; g < NUM_GAIN; g++) begin
					gain_reg[m][g] <= (g % (NUM_COMP + 1) == 0) ?
						GAIN_UNITY : GAIN_ZERO;
				end
			end
		end else begin
			nr_enable_reg <= nr_enable_next;
			refused_reg <= refused_next;
			rdata_reg <= rdata_next;
			th_reg <= th_next;
			tap_reg <= tap_next;
			nrg_reg <= nrg_next;
			mode_reg <= mode_next;
			offs_reg <= offs_next;
			gain_reg <= gain_next;
		end
	end

	assign REG_RDATA_O = rdata_reg;

	// ----------------------------------------------------------------
	// Horizontal noise reducer
	// ----------------------------------------------------------------
	// Stage 0 of the pixel pipe holds the noise reduced pixel.
	logic [PIX_W-1:0] stg_reg [NUM_MTX+1][NUM_COMP];
	logic [PIX_W-1:0] stg_next [NUM_MTX+1][NUM_COMP];
	logic [NUM_MTX:0] vld_reg, vld_next;
	logic [PIX_W-1:0] pix_in [NUM_COMP];

	assign pix_in[0] = PIX_YG_I;
	assign pix_in[1] = PIX_CBB_I;
	assign pix_in[2] = PIX_CRR_I;

	generate
		for (genvar c = 0; c < NUM_COMP; c++) begin : g_nr
			logic [PIX_W-1:0] hist_reg [HIST_DEPTH];
			logic [PIX_W-1:0] hist_next [HIST_DEPTH];

			always_comb begin
				logic [PIX_W-1:0] nb;
				int sum;
				int recip;
				int mean;
				int diff;
				int mag;
				int corr;
				nb = '0;
				sum = 0;
				recip = RECIP_1;
				mean = 0;
				diff = 0;
				mag = 0;
				corr = 0;
				hist_next = hist_reg;
				stg_next[0][c] = stg_reg[0][c];
				// The filter sees only the live input stream.
				if (PIX_VALID_I) begin
					for (int j = 0; j < HIST_DEPTH; j++) begin
						// A line start stops the previous line leaking in.
						nb = LINE_START_I ? pix_in[c] : hist_reg[j];
						if (j <= int'(tap_reg[c])) begin
							sum = sum + int'(nb);
						end
					end
					case (tap_reg[c])
						2'h0: recip = RECIP_1;
						2'h1: recip = RECIP_2;
						2'h2: recip = RECIP_3;
						default: recip = RECIP_4;
					endcase
					mean = (sum * recip) >>> RECIP_SHIFT;
					diff = mean - int'(pix_in[c]);
					mag = (diff < 0) ? -diff : diff;
					// Only small steps count as noise; edges pass.
					if (mag <= int'(th_reg[c])) begin
						corr = diff >>> (int'(nrg_reg[c]) + 1);
					end
					// Disabled means bypass, settings untouched.
					stg_next[0][c] = nr_enable_reg ?
						PIX_W'(int'(pix_in[c]) + corr) : pix_in[c];
					hist_next[0] = pix_in[c];
					for (int j = 1; j < HIST_DEPTH; j++) begin
						hist_next[j] = LINE_START_I ? pix_in[c] :
							hist_reg[j-1];
					end
				end
			end

			always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
				if (!RSTN_I) begin
					for (int j = 0; j < HIST_DEPTH; j++) begin
						hist_reg[j] <= '0;
					end
				end else begin
					hist_reg <= hist_next;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Colour matrices: input controller, improver 0, improver 1
	// ----------------------------------------------------------------
	generate
		for (genvar m = 0; m < NUM_MTX; m++) begin : g_mtx
			always_comb begin
				int x [NUM_COMP];
				int acc;
				logic ycc_in;
				logic ycc_out;
				acc = 0;
				for (int j = 0; j < NUM_COMP; j++) begin
					x[j] = 0;
				end
				ycc_in = (mode_reg[m] == MODE_YCC_GBR ||
					mode_reg[m] == MODE_YCC_YCC);
				ycc_out = (mode_reg[m] == MODE_GBR_YCC ||
					mode_reg[m] == MODE_YCC_YCC);
				for (int j = 0; j < NUM_COMP; j++) begin
					// Chroma is centred on mid scale before weighting.
					x[j] = int'(stg_reg[m][j]) -
						((ycc_in && j > 0) ? CHROMA_MID : 0);
				end
				for (int k = 0; k < NUM_COMP; k++) begin
					acc = 0;
					for (int j = 0; j < NUM_COMP; j++) begin
						acc = acc + int'($signed(
							gain_reg[m][k*NUM_COMP+j])) * x[j];
					end
					acc = (acc >>> UNITY_SHIFT) +
						int'(offs_reg[m][k]) - OFFS_ZERO;
					if (ycc_out && k > 0) begin
						acc = acc + CHROMA_MID;
					end
					// Clamp instead of wrapping so overflow stays visible
					// as full white or black.
					// A stage with no pixel in it keeps its last result, so
					// settings written between pixels never disturb an
					// idle output; the next pixel picks them up.
					if (!vld_reg[m]) begin
						stg_next[m+1][k] = stg_reg[m+1][k];
					end else if (acc < 0) begin
						stg_next[m+1][k] = '0;
					end else if (acc > PIX_MAX) begin
						stg_next[m+1][k] = PIX_W'(PIX_MAX);
					end else begin
						stg_next[m+1][k] = PIX_W'(acc);
					end
				end
			end
		end
	endgenerate

	assign vld_next = {vld_reg[NUM_MTX-1:0], PIX_VALID_I};

	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			vld_reg <= '0;
			for (int s = 0; s <= NUM_MTX; s++) begin
				for (int c = 0; c < NUM_COMP; c++) begin
					stg_reg[s][c] <= '0;
				end
			end
		end else begin
			vld_reg <= vld_next;
			stg_reg <= stg_next;
		end
	end

	assign PIX_VALID_O = vld_reg[NUM_MTX];
	assign PIX_YG_O = stg_reg[NUM_MTX][0];
	assign PIX_CBB_O = stg_reg[NUM_MTX][1];
	assign PIX_CRR_O = stg_reg[NUM_MTX][2];

endmodule

// ### tb/nr_mtx_properties.sv
// Purpose: Port properties of the noise reducer and matrix stage.
// Assumes: Register map and four-cycle latency of the package.
// Notes: An enable shadow lets reads be judged without the body.
`timescale 1ns/10ps
module nr_mtx_checker
	import nr_mtx_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RSTN_I,
	input wire logic [ADDR_W-1:0] REG_ADDR_I,
	input wire logic [DATA_W-1:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	input wire logic [DATA_W-1:0] REG_RDATA_O,
	input wire logic PIX_VALID_I,
	input wire logic PIX_VALID_O,
	input wire logic [PIX_W-1:0] PIX_YG_O
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	// The shadow follows writes only, so a stuck enable in the block shows.
	logic en_reg;
	always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			en_reg <= 1'b0;
		end else if (REG_WR_I && REG_ADDR_I == ADDR_NR_CTRL) begin
			en_reg <= REG_WDATA_I[NR_EN_BIT];
		end
	end
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RSTN_I);
	property p_lat;
		PIX_VALID_I |-> ##4 PIX_VALID_O;
	endproperty
	a_lat: assert property (p_lat) else $error("pixel latency off");
	property p_hold;
		!PIX_VALID_O |-> $stable(PIX_YG_O);
	endproperty
	a_hold: assert property (p_hold) else $error("idle output moved");
	property p_rdidle;
		!REG_RD_I |=> REG_RDATA_O == '0;
	endproperty
	a_rdidle: assert property (p_rdidle) else $error("stray read data");
	property p_en;
		REG_RD_I && REG_ADDR_I == ADDR_NR_CTRL
			|=> REG_RDATA_O == {31'h0, $past(en_reg)};
	endproperty
	a_en: assert property (p_en) else $error("enable readback");
	property p_stat;
		REG_RD_I && REG_ADDR_I == ADDR_STATUS
			|=> REG_RDATA_O[STAT_NR_ON_BIT] == $past(en_reg);
	endproperty
	a_stat: assert property (p_stat) else $error("status enable");
	property p_nrw;
		REG_RD_I && REG_ADDR_I inside {8'h10, 8'h14, 8'h18}
			|=> REG_RDATA_O[31:14] == '0 && REG_RDATA_O[11:10] == '0
			&& !REG_RDATA_O[7];
	endproperty
	a_nrw: assert property (p_nrw) else $error("parameter width");
	property p_ref;
		(REG_WR_I && REG_ADDR_I inside {8'h80, 8'hc0} && REG_WDATA_I[0])
			##1 (REG_RD_I && REG_ADDR_I == ADDR_STATUS)
			|=> REG_RDATA_O[STAT_REFUSED_BIT];
	endproperty
	a_ref: assert property (p_ref) else $error("refusal not flagged");
	property p_gain;
		REG_RD_I && REG_ADDR_I >= ADDR_MTX_BASE && REG_ADDR_I[5:0] >= 6'h10
			&& REG_ADDR_I[5:0] <= 6'h30 |=> REG_RDATA_O[31:11] == '0;
	endproperty
	a_gain: assert property (p_gain) else $error("gain width");
endmodule

bind video_nr_color_matrix nr_mtx_checker chk_u (
	.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .REG_ADDR_I(REG_ADDR_I),
	.REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_RDATA_O(REG_RDATA_O), .PIX_VALID_I(PIX_VALID_I),
	.PIX_VALID_O(PIX_VALID_O), .PIX_YG_O(PIX_YG_O));

// ### tb/tb_video_nr_color_matrix.sv
// Purpose: Self-checking bench of the noise reducer and colour matrices.
// Assumes: Identity matrices and a bypassed reducer after reset.
// Notes: Scenario order keeps the pixel path in a known state.
`timescale 1ns/10ps
module tb_video_nr_color_matrix
	import nr_mtx_pkg::*;
;
	// ----------------------------------------
	// Bench
	// ----------------------------------------
	logic clk, rstn, wr_s, rd_s;
	logic [7:0] addr;
	logic [31:0] wdata;
	wire [31:0] rdata;
	wire [23:0] pin, pout;
	wire vin, ls, vout;
	int miscompares = 0;
	int comparisons = 0;
	logic [23:0] exp_q[$];
	video_nr_color_matrix dut_u (.CORE_CLK_I(clk), .RSTN_I(rstn),
		.REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr_s),
		.REG_RD_I(rd_s), .REG_RDATA_O(rdata), .PIX_VALID_I(vin),
		.LINE_START_I(ls), .PIX_YG_I(pin[23:16]), .PIX_CBB_I(pin[15:8]),
		.PIX_CRR_I(pin[7:0]), .PIX_VALID_O(vout), .PIX_YG_O(pout[23:16]),
		.PIX_CBB_O(pout[15:8]), .PIX_CRR_O(pout[7:0]));
	video_peer_model src_u (.clk_i(clk), .valid_o(vin), .line_start_o(ls),
		.pix_o(pin), .valid_i(vout), .pix_i(pout));
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	// The write strobe stays up for a following write, so it is never
	// lowered and raised in one time step; a read or a pixel drops it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rd_s <= 1'b0;
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
	endtask
	// Read data stand one cycle only, so they are judged just after it opens.
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wr_s <= 1'b0;
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		chk("rdata", rdata, e);
	endtask
	task automatic px(input logic l, input logic [23:0] p, e);
		wr_s <= 1'b0;
		exp_q.push_back(e);
		src_u.push(l, p);
	endtask
	task automatic flush();
		src_u.idle();
		repeat (6) @(posedge clk);
		chk("count", src_u.got_q.size(), exp_q.size());
		while (exp_q.size() > 0 && src_u.got_q.size() > 0) begin
			chk("pixel", src_u.got_q.pop_front(), exp_q.pop_front());
		end
		src_u.got_q.delete();
		exp_q.delete();
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	initial begin
		rstn = 1'b0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		addr = '0;
		wdata = '0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		for (logic [7:0] i = 8'h0; i < 8'h3; i++) begin
			rd(ADDR_NR_PARAM + 8'h4 * i, 32'h3008);
		end
		rd(ADDR_NR_CTRL, 32'h0);
		rd(8'hfc, 32'h0);
		for (logic [7:0] m = 8'h0; m < 8'h3; m++) begin
			rd(8'h40 + 8'h40 * m, 32'h0);
			for (logic [7:0] k = 8'h0; k < 8'h9; k++) begin
				rd(8'h50 + 8'h40 * m + 8'h4 * k, {k[1:0] == 2'h0, 8'h0});
				if (k < 8'h3) rd(8'h44 + 8'h40 * m + 8'h4 * k, 32'h80);
			end
		end
		$display("reset values done");
		px(1'b1, 24'h0a141e, 24'h0a141e);
		px(1'b0, 24'hff0080, 24'hff0080);
		flush();
		$display("pass through done");
		wr(ADDR_NR_PARAM + 8'h4, 32'h3000);
		wr(ADDR_NR_PARAM + 8'h8, 32'h0008);
		wr(ADDR_NR_CTRL, 32'h1);
		px(1'b1, 24'h646464, 24'h646464);
		px(1'b0, 24'h686868, 24'h676866);
		px(1'b0, 24'h828282, 24'h828282);
		flush();
		rd(ADDR_STATUS, 32'h2);
		wr(ADDR_NR_CTRL, 32'h0);
		rd(ADDR_NR_PARAM + 8'h4, 32'h3000);
		rd(ADDR_NR_PARAM + 8'h8, 32'h0008);
		for (logic [31:0] t = 32'h0; t < 32'h4; t++) begin
			wr(ADDR_NR_PARAM, 32'h3008 | (t << 8));
			rd(ADDR_NR_PARAM, 32'h3008 | (t << 8));
		end
		wr(ADDR_NR_PARAM, 32'h0108);
		wr(ADDR_NR_CTRL, 32'h1);
		px(1'b1, 24'h646464, 24'h646464);
		px(1'b0, 24'h6a6a6a, 24'h676a67);
		px(1'b0, 24'h646464, 24'h656467);
		flush();
		wr(ADDR_NR_CTRL, 32'h0);
		$display("noise reducer done");
		for (logic [31:0] md = 32'h0; md < 32'h4; md++) begin
			wr(ADDR_MTX_BASE, md);
			rd(ADDR_MTX_BASE, md);
		end
		wr(ADDR_MTX_BASE, 32'h1);
		px(1'b1, 24'h0a141e, 24'h0a949e);
		flush();
		wr(ADDR_MTX_BASE, 32'h2);
		px(1'b1, 24'h0ac896, 24'h0a4816);
		flush();
		wr(ADDR_MTX_BASE, 32'h0);
		wr(8'h80, 32'h1);
		rd(ADDR_STATUS, 32'h1);
		rd(8'h80, 32'h0);
		wr(8'hc0, 32'h3);
		rd(8'hc0, 32'h0);
		wr(8'hc0, 32'h2);
		rd(8'hc0, 32'h2);
		wr(8'hc0, 32'h0);
		wr(ADDR_STATUS, 32'h1);
		rd(ADDR_STATUS, 32'h0);
		$display("matrix modes done");
		wr(8'h90, 32'h0);
		wr(8'h98, 32'h100);
		wr(8'ha0, 32'h700);
		wr(8'h88, 32'hff);
		wr(8'hc4, 32'hff);
		wr(8'hcc, 32'h0);
		rd(8'ha0, 32'h700);
		px(1'b0, 24'h0a141e, 24'h9d6b00);
		px(1'b0, 24'h0a14fa, 24'hff6b7a);
		flush();
		$display("matrix arithmetic done");
		tally_and_finish();
	end
endmodule

// ### tb/video_peer_model.sv
// Purpose: Video source and display sink around the pixel stage.
// Assumes: No backpressure; one pixel per push.
// Notes: Idle data lines are inverted so stale pixels cannot pass.
`timescale 1ns/10ps
module video_peer_model
	import nr_mtx_pkg::*;
(
	input wire logic clk_i,
	output logic valid_o,
	output logic line_start_o,
	output logic [3*PIX_W-1:0] pix_o,
	input wire logic valid_i,
	input wire logic [3*PIX_W-1:0] pix_i
);
	// ----------------------------------------
	// Source and sink
	// ----------------------------------------
	logic [3*PIX_W-1:0] got_q[$];
	initial begin
		valid_o = 1'b0;
		line_start_o = 1'b0;
		pix_o = '0;
	end
	// Video flows before any reducer setting is relied on.
	task automatic push(input logic ls, input logic [3*PIX_W-1:0] p);
		valid_o <= 1'b1;
		line_start_o <= ls;
		pix_o <= p;
		@(posedge clk_i);
	endtask
	task automatic idle();
		valid_o <= 1'b0;
		line_start_o <= 1'b0;
		pix_o <= ~pix_o;
	endtask
	always @(posedge clk_i) begin
		if (valid_i) begin
			got_q.push_back(pix_i);
		end
	end
endmodule
